// *** verilog/acm_defines.vh ***
// Offsets, field positions, reset values and counts for the clock config block
`ifndef ACM_DEFINES_VH
`define ACM_DEFINES_VH
// ==========================================================
// Register offsets
`define ACM_ADDR_MST_CFG0 8'h13
`define ACM_ADDR_RATE_RATIO 8'h14
`define ACM_ADDR_MON_STATUS 8'h15
`define ACM_ADDR_CLOCK_SOURCE_CONFIG 8'h16
`define ACM_ADDR_MIC_DIV 8'h1F
// ==========================================================
// Reset values
`define ACM_RST_MST_CFG0 8'h02
`define ACM_RST_RATE_RATIO 8'h48
`define ACM_RST_MON_STATUS 8'hFF
`define ACM_RST_CLOCK_SOURCE_CONFIG 8'h10
`define ACM_RST_MIC_DIV 8'h40
// ==========================================================
// Field positions
`define ACM_ROLE_BIT 7
`define ACM_AUTO_DIS_BIT 6
`define ACM_PLL_DIS_BIT 5
`define ACM_FAMILY_BIT 3
`define ACM_ROOT_SRC_BIT 7
`define ACM_SPEC_MODE_BIT 6
`define ACM_INV_BIT 1
// ==========================================================
// Codes and monitor timing
`define ACM_CODE_INVALID 4'hF
`define ACM_RATE_CODES 4'h9
`define ACM_RATIO_CODES 4'hD
`define ACM_CLK_HZ 25000000
`define ACM_MON_WINDOW_MS 1
`endif

// *** verilog/acm_period_meter.v ***
// Edge-to-edge period counter for one synchronised input level
`timescale 1ns/10ps
module acm_period_meter
(
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Synchronised level and measure window
  input wire level,
  input wire gate,
  // Count between two rising edges of level
  output reg [23:0] edge_count,
  output reg [11:0] rise_count,
  output reg fresh
);
  reg prev;
  reg [23:0] run;
  // ==========================================================
  // Counters
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      prev <= 1'b0;
      run <= 24'h000000;
      edge_count <= 24'h000000;
      rise_count <= 12'h000;
      fresh <= 1'b0;
    end
    else
    begin
      prev <= level;
      fresh <= 1'b0;
      if (level && !prev)
      begin
        edge_count <= run;
        run <= 24'h000001;
        fresh <= 1'b1;
        // Saturate so a stuck count never wraps to a valid value
        if (rise_count != 12'hFFF)
          rise_count <= rise_count + 12'h001;
      end
      else if (run != 24'hFFFFFF)
        run <= run + 24'h000001;
      if (gate)
        rise_count <= 12'h000;
    end
  end
endmodule // acm_period_meter

// *** verilog/acm_clk_divider.v ***
// Programmable divider that makes the microphone clock from the core clock
`timescale 1ns/10ps
module acm_clk_divider
(
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Half period in root ticks and root tick strobe
  input wire [7:0] half_period,
  input wire tick,
  // Divided clock
  output reg clk_out
);
  reg [7:0] cnt;
  // ==========================================================
  // Divider
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt <= 8'h00;
      clk_out <= 1'b0;
    end
    else if (tick)
    begin
      if (cnt + 8'h01 >= half_period)
      begin
        cnt <= 8'h00;
        clk_out <= ~clk_out;
      end
      else
        cnt <= cnt + 8'h01;
    end
  end
endmodule // acm_clk_divider

// *** verilog/acm_clock_config.v ***
// Audio bus clock configuration, monitor and microphone clock generation
// Operation
// - Rate code 0-8 selects frame rate
// - Ratio code 0-12 selects bitclk ratio
// - Slave auto mode ignores programmed rate, ratio
// - Detected rate status, 15 invalid, reset 1111b
// - Detected ratio status, 15 flags invalid
// - Slave auto no-PLL root: bitclk or refclk
// - Spec mode picks fixed freq or ratio in auto mode only
// - Refclk ratio field selects 64..2304
// - Master frame sync from inverted bitclk
// - Divider code sets microphone clock rate
// - Family bit chooses 48k or 44.1k
// - Role bit: slave inputs, master drives
// - PLL disable bit turns PLL off in auto mode only
`timescale 1ns/10ps
`include "acm_defines.vh"
module acm_clock_config
(
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  output reg [7:0] reg_rdata,
  // Audio bus clocks, two-way
  input wire bitclk_in,
  output reg bitclk_out,
  output wire bitclk_oe,
  input wire frame_sync_in,
  output reg frame_sync_out,
  output wire frame_sync_oe,
  // Reference clock input
  input wire refclk_in,
  // Microphone clock and clock tree state
  output wire mic_clock_out,
  output wire pll_enable,
  output wire root_is_refclk,
  output reg [15:0] refclk_ratio,
  output wire refclk_from_ratio,
  output wire [2:0] refclk_fixed_freq
);
  // ==========================================================
  // Registers
  reg [7:0] mst_cfg0;
  reg [7:0] master_rate_ratio_config;
  reg [7:0] clock_source_config;
  reg [7:0] mic_clock_divider_config;
  reg [3:0] detected_frame_rate;
  reg [3:0] detected_bitclk_frame_ratio;
  wire bus_role_select = mst_cfg0[`ACM_ROLE_BIT];
  wire auto_cfg = ~mst_cfg0[`ACM_AUTO_DIS_BIT];
  wire auto_pll_disable = mst_cfg0[`ACM_PLL_DIS_BIT];
  wire rate_family_select = mst_cfg0[`ACM_FAMILY_BIT];
  wire slave_root_source_select = clock_source_config[`ACM_ROOT_SRC_BIT];
  wire refclk_spec_mode = clock_source_config[`ACM_SPEC_MODE_BIT];
  wire invert_bitclk_for_framegen = clock_source_config[`ACM_INV_BIT];
  wire [3:0] programmed_frame_rate = master_rate_ratio_config[7:4];
  wire [3:0] programmed_bitclk_frame_ratio = master_rate_ratio_config[3:0];
  wire [2:0] refclk_ratio_sel = clock_source_config[5:3];
  wire [1:0] mic_clock_divider = mic_clock_divider_config[1:0];
  // Reserved bits are stored as written; software keeps them at reset
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mst_cfg0 <= `ACM_RST_MST_CFG0;
      master_rate_ratio_config <= `ACM_RST_RATE_RATIO;
      clock_source_config <= `ACM_RST_CLOCK_SOURCE_CONFIG;
      mic_clock_divider_config <= `ACM_RST_MIC_DIV;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ACM_ADDR_MST_CFG0: mst_cfg0 <= reg_wdata;
        `ACM_ADDR_RATE_RATIO: master_rate_ratio_config <= reg_wdata;
        `ACM_ADDR_CLOCK_SOURCE_CONFIG: clock_source_config <= reg_wdata;
        `ACM_ADDR_MIC_DIV: mic_clock_divider_config <= reg_wdata;
        default: mst_cfg0 <= mst_cfg0;
      endcase
    end
  end
  // Reads are pure muxes, status is never disturbed
  always @*
  begin
    case (reg_addr)
      `ACM_ADDR_MST_CFG0: reg_rdata = mst_cfg0;
      `ACM_ADDR_RATE_RATIO: reg_rdata = master_rate_ratio_config;
      `ACM_ADDR_MON_STATUS: reg_rdata = {detected_frame_rate,
        detected_bitclk_frame_ratio};
      `ACM_ADDR_CLOCK_SOURCE_CONFIG: reg_rdata = clock_source_config;
      `ACM_ADDR_MIC_DIV: reg_rdata = mic_clock_divider_config;
      default: reg_rdata = 8'h00;
    endcase
  end
  // ==========================================================
  // Code maps
  function [15:0] ratio_of;
    input [3:0] code;
    begin
      case (code)
        4'h0: ratio_of = 16'h0010;
        4'h1: ratio_of = 16'h0018;
        4'h2: ratio_of = 16'h0020;
        4'h3: ratio_of = 16'h0030;
        4'h4: ratio_of = 16'h0040;
        4'h5: ratio_of = 16'h0060;
        4'h6: ratio_of = 16'h0080;
        4'h7: ratio_of = 16'h00C0;
        4'h8: ratio_of = 16'h0100;
        4'h9: ratio_of = 16'h0180;
        4'hA: ratio_of = 16'h0200;
        4'hB: ratio_of = 16'h0400;
        4'hC: ratio_of = 16'h0800;
        default: ratio_of = 16'h0000;
      endcase
    end
  endfunction
  // Frame rate in 8 kHz units, family scaling applied separately
  function [6:0] rate_units;
    input [3:0] code;
    begin
      case (code)
        4'h0: rate_units = 7'h01;
        4'h1: rate_units = 7'h02;
        4'h2: rate_units = 7'h03;
        4'h3: rate_units = 7'h04;
        4'h4: rate_units = 7'h06;
        4'h5: rate_units = 7'h0C;
        4'h6: rate_units = 7'h18;
        4'h7: rate_units = 7'h30;
        4'h8: rate_units = 7'h60;
        default: rate_units = 7'h00;
      endcase
    end
  endfunction
  always @*
  begin
    case (refclk_ratio_sel)
      3'h0: refclk_ratio = 16'h0040;
      3'h1: refclk_ratio = 16'h0100;
      3'h2: refclk_ratio = 16'h0180;
      3'h3: refclk_ratio = 16'h0200;
      3'h4: refclk_ratio = 16'h0300;
      3'h5: refclk_ratio = 16'h0400;
      3'h6: refclk_ratio = 16'h0600;
      default: refclk_ratio = 16'h0900;
    endcase
  end
  // ==========================================================
  // Clock tree selection
  wire slave_auto = !bus_role_select && auto_cfg;
  assign pll_enable = !(auto_cfg && auto_pll_disable);
  assign root_is_refclk = slave_auto && auto_pll_disable
    && slave_root_source_select;
  assign refclk_from_ratio = auto_cfg && refclk_spec_mode;
  assign refclk_fixed_freq = mst_cfg0[2:0];
  // ==========================================================
  // Input synchronisers
  reg [1:0] bclk_sync;
  reg [1:0] frame_sync_sync;
  reg [1:0] ref_sync;
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bclk_sync <= 2'b00;
      frame_sync_sync <= 2'b00;
      ref_sync <= 2'b00;
    end
    else
    begin
      bclk_sync <= {bclk_sync[0], bitclk_in};
      frame_sync_sync <= {frame_sync_sync[0], frame_sync_in};
      ref_sync <= {ref_sync[0], refclk_in};
    end
  end
  // ==========================================================
  // Master-side bus clock generation
  // Phase accumulator keeps the average rate exact; edges jitter one cycle
  reg [15:0] bit_in_frame;
  reg [31:0] phase;
  wire [15:0] frame_bits = ratio_of(programmed_bitclk_frame_ratio);
  wire [6:0] units = rate_units(programmed_frame_rate);
  // Toggle step per core cycle, limited to half the core rate
  wire [31:0] bit_hz = {25'h0000000, units} * (rate_family_select ?
    32'd7350 : 32'd8000) * {16'h0000, frame_bits};
  wire [31:0] bit_step = (bit_hz > `ACM_CLK_HZ / 2) ? `ACM_CLK_HZ :
    bit_hz * 32'h00000002;
  wire master_on = bus_role_select;
  wire gen_ok = !slave_auto && units != 7'h00 && frame_bits != 16'h0000;
  reg bclk_prev;
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      phase <= 32'h00000000;
      bitclk_out <= 1'b0;
      bclk_prev <= 1'b0;
      bit_in_frame <= 16'h0000;
      frame_sync_out <= 1'b0;
    end
    else if (master_on && gen_ok)
    begin
      bclk_prev <= bitclk_out;
      if (phase + bit_step >= `ACM_CLK_HZ)
      begin
        phase <= phase + bit_step - `ACM_CLK_HZ;
        bitclk_out <= ~bitclk_out;
      end
      else
        phase <= phase + bit_step;
      // Frame edge is launched on the selected bit clock edge
      if ((invert_bitclk_for_framegen ? (bclk_prev && !bitclk_out)
        : (!bclk_prev && bitclk_out)))
      begin
        if (bit_in_frame + 16'h0001 >= frame_bits)
          bit_in_frame <= 16'h0000;
        else
          bit_in_frame <= bit_in_frame + 16'h0001;
        frame_sync_out <= (bit_in_frame + 16'h0001 >= frame_bits);
      end
    end
    else
    begin
      bitclk_out <= 1'b0;
      frame_sync_out <= 1'b0;
      bit_in_frame <= 16'h0000;
    end
  end
  assign bitclk_oe = master_on;
  assign frame_sync_oe = master_on;
  // ==========================================================
  // Clock monitor
  // Bit clock edges per frame give the ratio; frame period gives the rate
  wire [23:0] frame_period;
  wire [11:0] bits_seen;
  wire frame_fresh;
  wire [23:0] unused_period;
  wire [11:0] unused_bits;
  wire unused_fresh;
  reg [15:0] bit_count;
  reg bprev;
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bit_count <= 16'h0000;
      bprev <= 1'b0;
    end
    else
    begin
      bprev <= bclk_sync[1];
      if (frame_fresh)
        bit_count <= 16'h0000;
      else if (bclk_sync[1] && !bprev && bit_count != 16'hFFFF)
        bit_count <= bit_count + 16'h0001;
    end
  end
  acm_period_meter u_frame_meter
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(frame_sync_sync[1]),
    .gate(1'b0),
    .edge_count(frame_period),
    .rise_count(bits_seen),
    .fresh(frame_fresh)
  );
  acm_period_meter u_ref_meter
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(ref_sync[1]),
    .gate(frame_fresh),
    .edge_count(unused_period),
    .rise_count(unused_bits),
    .fresh(unused_fresh)
  );
  // Match frame period against each rate code within two core cycles; bit count must match the ratio exactly
  integer i;
  reg [3:0] next_rate;
  reg [3:0] next_ratio;
  reg [31:0] expect_p;
  reg [31:0] expect_q;
  always @*
  begin
    next_rate = `ACM_CODE_INVALID;
    next_ratio = `ACM_CODE_INVALID;
    expect_p = 32'h00000000;
    expect_q = 32'h00000000;
    for (i = 0; i < 9; i = i + 1)
    begin
      expect_p = `ACM_CLK_HZ / ({25'h0000000, rate_units(i[3:0])} * 8000);
      expect_q = `ACM_CLK_HZ / ({25'h0000000, rate_units(i[3:0])} * 7350);
      if (({8'h00, frame_period} + 32'd2 >= expect_p &&
        {8'h00, frame_period} <= expect_p + 32'd2) ||
        ({8'h00, frame_period} + 32'd2 >= expect_q &&
        {8'h00, frame_period} <= expect_q + 32'd2))
        next_rate = i[3:0];
    end
    for (i = 0; i < 13; i = i + 1)
      if (bit_count == ratio_of(i[3:0]))
        next_ratio = i[3:0];
  end
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      detected_frame_rate <= `ACM_CODE_INVALID;
      detected_bitclk_frame_ratio <= `ACM_CODE_INVALID;
    end
    else if (frame_fresh)
    begin
      detected_frame_rate <= next_rate;
      detected_bitclk_frame_ratio <= next_ratio;
    end
  end
  // ==========================================================
  // Microphone clock
  // Divides the core clock; 44.1k family rates are approximated
  reg [7:0] mic_half;
  always @*
  begin
    case (mic_clock_divider)
      2'h0: mic_half = 8'h04;
      2'h1: mic_half = 8'h08;
      2'h2: mic_half = 8'h10;
      default: mic_half = 8'h02;
    endcase
  end
  acm_clk_divider u_mic_div
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .half_period(mic_half),
    .tick(1'b1),
    .clk_out(mic_clock_out)
  );
endmodule // acm_clock_config

// *** tb/acm_clock_config_props.sv ***
// Checker for the clock configuration block ports
`timescale 1ns/10ps
module acm_clock_config_props
(
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire [7:0] reg_rdata,
  // Bus pins and clock tree
  input wire frame_sync_in,
  input wire bitclk_oe,
  input wire frame_sync_oe,
  input wire mic_clock_out,
  input wire pll_enable,
  input wire root_is_refclk,
  input wire [15:0] refclk_ratio,
  input wire refclk_from_ratio,
  input wire [2:0] refclk_fixed_freq
);
  localparam [127:0] RT = {16'h0900, 16'h0600, 16'h0400, 16'h0300,
    16'h0200, 16'h0180, 16'h0100, 16'h0040};
  reg [7:0] r13;
  reg [7:0] r16;
  reg [1:0] r1f;
  reg [5:0] age;
  reg [5:0] run;
  reg [3:0] low;
  reg mic_q;
  wire [5:0] half = (r1f == 2'h3) ? 6'h02 : (6'h04 << r1f);
  // ==========================================================
  // Shadow registers
  always @(posedge core_clk)
  begin
    mic_q <= mic_clock_out;
    run <= (mic_clock_out != mic_q) ? 6'h01 : run + 6'h01;
    low <= frame_sync_in ? 4'h0 : ((low == 4'hF) ? low : low + 4'h1);
    // A write to 0x1F or 0x13 restarts the settle time of the divider
    if (!rst_n || (reg_wr && (reg_addr == 8'h1F || reg_addr == 8'h13)))
      age <= 6'h00;
    else if (age != 6'h3F)
      age <= age + 6'h01;
    if (!rst_n)
    begin
      r13 <= 8'h02;
      r16 <= 8'h10;
      r1f <= 2'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h13)
        r13 <= reg_wdata;
      if (reg_addr == 8'h16)
        r16 <= reg_wdata;
      if (reg_addr == 8'h1F)
        r1f <= reg_wdata[1:0];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_oe_role;
    bitclk_oe == r13[7] && frame_sync_oe == r13[7];
  endproperty
  a_oe_role: assert property (p_oe_role)
    else $error("bus enables do not follow role");
  property p_pll;
    !r13[6] |-> pll_enable == !r13[5];
  endproperty
  a_pll: assert property (p_pll)
    else $error("pll enable wrong");
  property p_root;
    !r13[7] && !r13[6] && r13[5] |-> root_is_refclk == r16[7];
  endproperty
  a_root: assert property (p_root)
    else $error("root source wrong");
  property p_spec;
    !r13[6] |-> refclk_from_ratio == r16[6];
  endproperty
  a_spec: assert property (p_spec)
    else $error("refclk spec mode wrong");
  property p_ratio;
    $past(rst_n) && !$past(reg_wr) |-> refclk_ratio == RT[r16[5:3]*16 +: 16];
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("refclk ratio decode wrong");
  property p_fixed;
    $past(rst_n) && !$past(reg_wr) |-> refclk_fixed_freq == r13[2:0];
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed frequency field wrong");
  property p_mic;
    mic_clock_out != mic_q && age == 6'h3F && !r13[5] |-> run == half;
  endproperty
  a_mic: assert property (p_mic)
    else $error("mic clock half period wrong");
  property p_hold;
    reg_addr == 8'h15 && $past(reg_addr) == 8'h15 && low > 4'h5 &&
      !r13[7] && !$past(reg_wr) |-> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("status moved between frames");
endmodule // acm_clock_config_props
bind acm_clock_config acm_clock_config_props u_acm_clock_config_props
(
  .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
  .frame_sync_in, .bitclk_oe, .frame_sync_oe, .mic_clock_out,
  .pll_enable, .root_is_refclk, .refclk_ratio, .refclk_from_ratio,
  .refclk_fixed_freq
);

// *** tb/acm_bus_model.sv ***
// Host side of the audio bus: bit clock and frame sync source
`timescale 1ns/10ps
module acm_bus_model
(
  // Control
  input wire run,
  input wire [31:0] frame_ns,
  input wire [11:0] ratio,
  // Bus clocks
  output reg bitclk,
  output reg frame_sync
);
  real half;
  integer i;
  initial
  begin
    bitclk = 1'b0;
    frame_sync = 1'b0;
  end
  // Whole frames only; clocks stand still when stopped
  always
  begin
    wait (run);
    half = frame_ns / (2.0 * ratio);
    for (i = 0; i < ratio; i = i + 1)
    begin
      bitclk = 1'b0;
      if (i == 0 || i == ratio / 2)
        frame_sync = (i == 0);
      #(half);
      bitclk = 1'b1;
      #(half);
    end
  end
endmodule // acm_bus_model

// *** tb/tb.sv ***
// Testbench for the clock configuration block
`timescale 1ns/10ps
module tb;
  localparam [55:0] AD = 56'h17_00_1F_16_15_14_13;
  localparam [55:0] EV = 56'h00_00_40_10_FF_48_02;
  localparam [127:0] RT = {16'h0900, 16'h0600, 16'h0400, 16'h0300,
    16'h0200, 16'h0180, 16'h0100, 16'h0040};
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg refclk_in = 1'b0;
  reg run = 1'b0;
  reg [31:0] frame_ns = 32'h0000_5161;
  reg [11:0] ratio = 12'h040;
  reg pb, pf, b0, b1;
  integer bad_count = 0;
  integer cmp_count = 0;
  integer i, n, cyc, rises;
  wire [7:0] reg_rdata;
  wire bitclk_out, bitclk_oe, frame_sync_out, frame_sync_oe;
  wire host_bclk, host_fs, mic_clock_out, pll_enable;
  wire root_is_refclk, refclk_from_ratio;
  wire [15:0] refclk_ratio;
  wire [2:0] refclk_fixed_freq;
  // Pin level from whichever side drives it
  wire bitclk_w = bitclk_oe ? bitclk_out : host_bclk;
  wire fs_w = frame_sync_oe ? frame_sync_out : host_fs;
  always #20 core_clk = ~core_clk;
  always #37 refclk_in = ~refclk_in;
  acm_clock_config u_acm_clock_config
  (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .bitclk_in(bitclk_w), .bitclk_out(bitclk_out), .bitclk_oe(bitclk_oe),
    .frame_sync_in(fs_w), .frame_sync_out(frame_sync_out),
    .frame_sync_oe(frame_sync_oe), .refclk_in(refclk_in),
    .mic_clock_out(mic_clock_out), .pll_enable(pll_enable),
    .root_is_refclk(root_is_refclk), .refclk_ratio(refclk_ratio),
    .refclk_from_ratio(refclk_from_ratio),
    .refclk_fixed_freq(refclk_fixed_freq)
  );
  acm_bus_model u_acm_bus_model
  (
    .run(run), .frame_ns(frame_ns), .ratio(ratio),
    .bitclk(host_bclk), .frame_sync(host_fs)
  );
  // ==========================================================
  // Tasks
  task check(input [8*8-1:0] what, input [15:0] exp, input [15:0] got);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] %0s exp %h got %h", what, exp, got);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
  begin
    @(negedge core_clk);
    reg_addr = a;
    #5;
    check("rdata", {8'h00, exp}, {8'h00, reg_rdata});
  end
  endtask
  task mic(input [1:0] c);
  begin
    wr(8'h1F, {6'h10, c});
    repeat (80) @(negedge core_clk);
    n = 0;
    b0 = mic_clock_out;
    while (!(b0 === 1'b0 && mic_clock_out === 1'b1) && n < 100)
    begin
      b0 = mic_clock_out;
      @(negedge core_clk);
      n = n + 1;
    end
    cyc = 0;
    while (mic_clock_out === 1'b1 && cyc < 100)
    begin
      @(negedge core_clk);
      cyc = cyc + 1;
    end
    check("mic half", (c == 2'h3) ? 16'h0002 : (16'h0004 << c), cyc[15:0]);
  end
  endtask
  task step;
  begin
    pb = bitclk_out;
    pf = frame_sync_out;
    @(negedge core_clk);
    cyc = cyc + 1;
    if (pb === 1'b0 && bitclk_out === 1'b1)
      rises = rises + 1;
  end
  endtask
  task to_frame;
  begin
    n = 0;
    step;
    while (!(pf === 1'b0 && frame_sync_out === 1'b1) && n < 5000)
    begin
      step;
      n = n + 1;
    end
  end
  endtask
  // Master framing: bit clocks per frame exact, length within 3 percent
  task mframe(input [7:0] m13, input [7:0] m14, input [15:0] er,
    input integer ec);
  begin
    wr(8'h13, m13);
    wr(8'h14, m14);
    repeat (1500) @(negedge core_clk);
    to_frame;
    b0 = bitclk_out;
    cyc = 0;
    rises = 0;
    to_frame;
    check("bclk cnt", er, rises[15:0]);
    check("frm len", 16'h0001, {15'h0, cyc*100 > ec*97 && cyc*100 < ec*103});
  end
  endtask
  task slave(input integer fns, input [11:0] r, input [7:0] exp);
  begin
    frame_ns = fns;
    ratio = r;
    run = 1'b1;
    #(fns * 4);
    rd(8'h15, exp);
    rd(8'h15, exp);
  end
  endtask
  task test_done;
  begin
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    for (i = 0; i < 7; i = i + 1)
      rd(AD[i*8 +: 8], EV[i*8 +: 8]);
    wr(8'h15, 8'h00);
    rd(8'h15, 8'hFF);
    for (i = 0; i < 4; i = i + 1)
      mic(i[1:0]);
    wr(8'h14, 8'h00);
    slave(5208, 12'h018, 8'h61);
    slave(20833, 12'h040, 8'h44);
    slave(22676, 12'h040, 8'h44);
    slave(100000, 12'h014, 8'hFF);
    slave(125000, 12'h010, 8'h00);
    run = 1'b0;
    mframe(8'h82, 8'h44, 16'h0040, 521);
    mframe(8'h8A, 8'h44, 16'h0040, 567);
    mframe(8'h82, 8'h40, 16'h0010, 521);
    mframe(8'h82, 8'h52, 16'h0020, 260);
    check("oe", 16'h0001, {15'h0, bitclk_oe & frame_sync_oe});
    b1 = b0;
    wr(8'h16, 8'h12);
    mframe(8'h82, 8'h52, 16'h0020, 260);
    check("fs phase", 16'h0001, {15'h0, b0 !== b1});
    wr(8'h13, 8'h20);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h16, {2'h3, i[2:0], 3'h0});
      rd(8'h16, {2'h3, i[2:0], 3'h0});
      check("ratio", RT[i*16 +: 16], refclk_ratio);
      check("tree", 16'h0006, {13'h0, root_is_refclk, refclk_from_ratio,
        pll_enable});
    end
    test_done;
  end
  // Expected run is about 1.5 ms; the limit leaves ample margin
  initial
  begin
    #3500000;
    bad_count = bad_count + 1;
    test_done;
  end
endmodule // tb
